/* pkg/tpc_pkg.sv */
// Register map, field positions and codes of the timer control block
package tpc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_FWC  = 8'h26;
    localparam logic [7:0] IDX_CDC  = 8'h27;
    localparam logic [7:0] IDX_CLK  = 8'h30;
    localparam logic [7:0] IDX_CMPD = 8'h31;
    localparam logic [7:0] IDX_STAT = 8'h32;
    localparam logic [7:0] FWC_RST  = 8'h00;
    localparam logic [7:0] CDC_RST  = 8'h00;
    localparam logic [4:0] CLK_RST  = 5'h00;
    localparam logic [9:0] CMPD_RST = 10'h000;
    localparam int FWC_IRQ_EN   = 7;
    localparam int FWC_MODE_EN  = 6;
    localparam int FWC_NOISE    = 5;
    localparam int FWC_EDGE     = 4;
    localparam int FWC_COMP     = 3;
    localparam int FWC_FLAG     = 2;
    localparam int FWC_WGM_LSB  = 0;
    localparam int CDC_A_SH_LSB = 6;
    localparam int CDC_B_SH_LSB = 4;
    localparam int CDC_D_LSB    = 2;
    localparam int CDC_FORCE    = 1;
    localparam int CDC_PWM      = 0;
    localparam int CLK_ASYNC    = 4;
    localparam int PRESC_W      = 14;
    localparam logic [1:0] FILT_LAST = 2'h3;
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOG = 2'h1;
    localparam logic [1:0] COM_CLR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
    typedef enum logic [2:0] {
        WM_NORMAL = 3'b000,
        WM_FAST   = 3'b001,
        WM_PFC    = 3'b010,
        WM_SS6    = 3'b011,
        WM_DS6    = 3'b100
    } tpc_wave_mode_t;
    function automatic logic [11:0] tpc_reg_addr(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction
    // Non-PWM compare action
    function automatic logic tpc_com_action(input logic [1:0] com, input logic wave);
        case (com)
            COM_TOG: return !wave;
            COM_CLR: return 1'b0;
            COM_SET: return 1'b1;
            default: return wave;
        endcase
    endfunction
endpackage

/* pkg/tpc_core_if.sv */
// Signals between the control core, prescaler and fault front end
`timescale 1ns/1ps
interface tpc_core_if;
    logic [3:0] clk_sel;
    logic       src_en;
    logic       tick;
    logic       noise_en;
    logic       edge_sel;
    logic       comp_src;
    logic       mode_en;
    logic       fault_event;
    logic       fault_level;
    modport ctrl  (output clk_sel, src_en, noise_en, edge_sel, comp_src, mode_en,
                   input tick, fault_event, fault_level);
    modport presc (input clk_sel, src_en, output tick);
    modport fault (input noise_en, edge_sel, comp_src, mode_en, output fault_event, fault_level);
endinterface

/* design/tpc_prescaler.sv */
// Timer clock prescaler producing a one-cycle tick enable
`timescale 1ns/1ps
module tpc_prescaler (
    input  wire logic  clk_in,
    input  wire logic  rst_n_in,
    tpc_core_if.presc  bus
);
    logic [tpc_pkg::PRESC_W-1:0] div_cnt;
    logic [15:0]                 span;
    logic [tpc_pkg::PRESC_W-1:0] mask;

    always_comb begin
        span = 16'h0001 << bus.clk_sel;
        mask = tpc_pkg::PRESC_W'(span[15:1] - 15'h0001);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_cnt <= '0;
        end else if (bus.clk_sel == 4'h0) begin
            div_cnt <= '0;
        end else if (bus.src_en) begin
            div_cnt <= div_cnt + tpc_pkg::PRESC_W'(1);
        end
    end

    assign bus.tick = bus.src_en && (bus.clk_sel != 4'h0) && ((div_cnt & mask) == mask);

    property p_presc_undiv;
        @(posedge clk_in) disable iff (!rst_n_in) (bus.clk_sel == 4'h1) |-> (bus.tick == bus.src_en);
    endproperty
    a_presc_undiv: assert property (p_presc_undiv) else $error("undivided select does not pass source");
    property p_presc_stop;
        @(posedge clk_in) disable iff (!rst_n_in) (bus.clk_sel == 4'h0) [*2] |-> !bus.tick;
    endproperty
    a_presc_stop: assert property (p_presc_stop) else $error("tick while timer stopped");
endmodule

/* design/tpc_fault_front.sv */
// Fault input synchroniser, source select, noise filter and edge detector
`timescale 1ns/1ps
module tpc_fault_front (
    input  wire logic  clk_in,
    input  wire logic  rst_n_in,
    input  wire logic  fault_input_pin_in,
    input  wire logic  comparator_in,
    tpc_core_if.fault  bus
);
    logic [2:0] pin_sy;
    logic [2:0] cmp_sy;
    logic       pin_lvl;
    logic       cmp_lvl;
    logic       src;
    logic [1:0] eq_cnt;
    logic       filt;
    logic       filt_d;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_sy  <= 3'h0;
            cmp_sy  <= 3'h0;
            pin_lvl <= 1'b0;
            cmp_lvl <= 1'b0;
        end else begin
            pin_sy <= {pin_sy[1:0], fault_input_pin_in};
            cmp_sy <= {cmp_sy[1:0], comparator_in};
            if (pin_sy[1] == pin_sy[2]) begin
                pin_lvl <= pin_sy[2];
            end
            if (cmp_sy[1] == cmp_sy[2]) begin
                cmp_lvl <= cmp_sy[2];
            end
        end
    end

    assign src = bus.comp_src ? cmp_lvl : pin_lvl;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            eq_cnt <= 2'h0;
            filt   <= 1'b0;
            filt_d <= 1'b0;
        end else begin
            filt_d <= filt;
            if (!bus.noise_en || src == filt) begin
                eq_cnt <= 2'h0;
                filt   <= src;
            end else if (eq_cnt == tpc_pkg::FILT_LAST) begin
                eq_cnt <= 2'h0;
                filt   <= src;
            end else begin
                eq_cnt <= eq_cnt + 2'h1;
            end
        end
    end

    assign bus.fault_level = filt;
    assign bus.fault_event = bus.mode_en && (bus.edge_sel ? (filt && !filt_d) : (!filt && filt_d));

    property p_filter;
        @(posedge clk_in) disable iff (!rst_n_in)
        ($changed(filt) && $past(bus.noise_en) && $past(bus.noise_en, 4))
        |-> ($past(src) == filt) && ($past(src, 2) == filt) && ($past(src, 3) == filt) && ($past(src, 4) == filt);
    endproperty
    a_filter: assert property (p_filter) else $error("filter changed before four equal samples");
endmodule

/* design/tpc_top.sv */
// Timer prescale, compare channel D and fault protection control with APB registers
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module tpc_top (
    input  wire logic        clk_sys_in,
    input  wire logic        nrst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        fast_periph_clk_in,
    input  wire logic [9:0]  timer_count_in,
    input  wire logic        count_down_in,
    output logic             timer_tick_out,
    output logic             timer_enable_out,
    output logic [2:0]       wave_mode_out,
    output logic [1:0]       chan_a_mode_shadow_out,
    output logic [1:0]       chan_b_mode_shadow_out,
    output logic             chan_d_match_out,
    output logic             chan_d_waveform_out,
    input  wire logic        chan_d_dir_in,
    input  wire logic        chan_d_inv_dir_in,
    output logic             chan_d_compare_pin_out,
    output logic             chan_d_compare_pin_oe_out,
    output logic             chan_d_override_out,
    output logic             chan_d_inv_pin_out,
    output logic             chan_d_inv_pin_oe_out,
    output logic             chan_d_inv_override_out,
    input  wire logic        fault_input_pin_in,
    input  wire logic        comparator_in,
    input  wire logic        fault_irq_ack_in,
    output logic             fault_irq_out,
    output logic             fault_protect_out
);
    tpc_core_if u_core_if ();

    logic [1:0] rst_sy;
    logic       rst_n;

    // Register state
    logic [7:0] fwc;
    logic       fault_flag;
    logic       clr_pend;
    logic [7:0] cdc;
    logic [4:0] clk_cfg;
    logic [9:0] chan_d_compare_value;

    // APB decode
    logic       setup;
    logic       wr;
    logic       hit_fwc;
    logic       hit_cdc;
    logic       hit_clk;
    logic       hit_cmpd;
    logic       hit_stat;
    logic [31:0] rd_mux;

    // Channel D
    tpc_pkg::tpc_wave_mode_t wmode;
    logic [1:0] com_d;
    logic [9:0] prev_count;
    logic       arrive;
    logic       match_d;
    logic       zero_d;
    logic       force_now;
    logic       next_wave;
    logic       wave;
    logic       wave_n;
    logic       inv_conn;
    logic       hold;

    // Reset release through two flip-flops
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_sy <= 2'h0;
        end else begin
            rst_sy <= {rst_sy[0], 1'b1};
        end
    end
    assign rst_n = rst_sy[1];

    assign setup    = psel_in && !penable_in;
    assign wr       = psel_in && penable_in && pwrite_in;
    assign hit_fwc  = paddr_in == tpc_pkg::tpc_reg_addr(tpc_pkg::IDX_FWC);
    assign hit_cdc  = paddr_in == tpc_pkg::tpc_reg_addr(tpc_pkg::IDX_CDC);
    assign hit_clk  = paddr_in == tpc_pkg::tpc_reg_addr(tpc_pkg::IDX_CLK);
    assign hit_cmpd = paddr_in == tpc_pkg::tpc_reg_addr(tpc_pkg::IDX_CMPD);
    assign hit_stat = paddr_in == tpc_pkg::tpc_reg_addr(tpc_pkg::IDX_STAT);
    assign pready_out = 1'b1;

    // Read data; force bit of cdc is never stored
    always_comb begin
        rd_mux = '0;
        if (hit_fwc) begin
            rd_mux = 32'({fwc[7:3], fault_flag, fwc[1:0]});
        end else if (hit_cdc) begin
            rd_mux = 32'(cdc);
        end else if (hit_clk) begin
            rd_mux = 32'(clk_cfg);
        end else if (hit_cmpd) begin
            rd_mux = 32'(chan_d_compare_value);
        end else if (hit_stat) begin
            rd_mux = 32'({hold, u_core_if.fault_level, timer_enable_out, wave});
        end
    end

    // Answer captured in the setup phase, valid through the access phase
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            prdata_out  <= '0;
            pslverr_out <= 1'b0;
        end else if (setup) begin
            prdata_out  <= pwrite_in ? 32'h0000_0000 : rd_mux;
            pslverr_out <= !(hit_fwc || hit_cdc || hit_clk || hit_cmpd || hit_stat);
        end
    end

    // Control registers
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            fwc                  <= tpc_pkg::FWC_RST;
            cdc                  <= tpc_pkg::CDC_RST;
            clk_cfg              <= tpc_pkg::CLK_RST;
            chan_d_compare_value <= tpc_pkg::CMPD_RST;
        end else if (wr) begin
            if (hit_fwc) begin
                fwc <= {pwdata_in[7:3], 1'b0, pwdata_in[1:0]};
            end
            if (hit_cdc) begin
                cdc <= {pwdata_in[7:2], 1'b0, pwdata_in[0]};
            end
            if (hit_clk) begin
                clk_cfg <= pwdata_in[4:0];
            end
            if (hit_cmpd) begin
                chan_d_compare_value <= pwdata_in[9:0];
            end
        end
    end

    // Fault flag: an event in the clearing cycle wins
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            clr_pend   <= 1'b0;
            fault_flag <= 1'b0;
        end else begin
            clr_pend <= wr && hit_fwc && pwdata_in[tpc_pkg::FWC_FLAG];
            if (u_core_if.fault_event) begin
                fault_flag <= 1'b1;
            end else if (clr_pend || fault_irq_ack_in) begin
                fault_flag <= 1'b0;
            end
        end
    end

    assign fault_irq_out     = fault_flag && fwc[tpc_pkg::FWC_IRQ_EN];
    assign hold              = fwc[tpc_pkg::FWC_MODE_EN] && fault_flag;
    assign fault_protect_out = hold;

    assign u_core_if.mode_en  = fwc[tpc_pkg::FWC_MODE_EN];
    assign u_core_if.noise_en = fwc[tpc_pkg::FWC_NOISE];
    assign u_core_if.edge_sel = fwc[tpc_pkg::FWC_EDGE];
    assign u_core_if.comp_src = fwc[tpc_pkg::FWC_COMP];

    // Prescaler source: fast clock enable in async mode, every cycle otherwise
    assign u_core_if.clk_sel = clk_cfg[3:0];
    assign u_core_if.src_en  = clk_cfg[tpc_pkg::CLK_ASYNC] ? fast_periph_clk_in : 1'b1;
    assign timer_tick_out    = u_core_if.tick;
    assign timer_enable_out  = clk_cfg[3:0] != 4'h0;

    assign chan_a_mode_shadow_out = cdc[tpc_pkg::CDC_A_SH_LSB +: 2];
    assign chan_b_mode_shadow_out = cdc[tpc_pkg::CDC_B_SH_LSB +: 2];

    // Waveform mode
    always_comb begin
        if (!cdc[tpc_pkg::CDC_PWM]) begin
            wmode = tpc_pkg::WM_NORMAL;
        end else begin
            case (fwc[tpc_pkg::FWC_WGM_LSB +: 2])
                2'h0:    wmode = tpc_pkg::WM_FAST;
                2'h1:    wmode = tpc_pkg::WM_PFC;
                2'h2:    wmode = tpc_pkg::WM_SS6;
                2'h3:    wmode = tpc_pkg::WM_DS6;
                default: wmode = tpc_pkg::WM_NORMAL;
            endcase
        end
    end
    assign wave_mode_out = wmode;
    assign com_d         = cdc[tpc_pkg::CDC_D_LSB +: 2];

    // Match only when the counter arrives at the value, not on a static equality
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            prev_count       <= 10'h000;
            chan_d_match_out <= 1'b0;
        end else begin
            prev_count       <= timer_count_in;
            chan_d_match_out <= match_d;
        end
    end
    assign arrive  = timer_count_in != prev_count;
    assign match_d = arrive && (timer_count_in == chan_d_compare_value);
    assign zero_d  = arrive && (timer_count_in == 10'h000);

    // Force uses the mode and PWM bit written in the same access
    assign force_now = wr && hit_cdc && pwdata_in[tpc_pkg::CDC_FORCE]
                       && !pwdata_in[tpc_pkg::CDC_PWM];

    always_comb begin
        next_wave = wave;
        if (force_now) begin
            next_wave = tpc_pkg::tpc_com_action(pwdata_in[tpc_pkg::CDC_D_LSB +: 2], wave);
        end else if (com_d != tpc_pkg::COM_OFF) begin
            case (wmode)
                tpc_pkg::WM_NORMAL: begin
                    if (match_d) begin
                        next_wave = tpc_pkg::tpc_com_action(com_d, wave);
                    end
                end
                tpc_pkg::WM_FAST, tpc_pkg::WM_SS6: begin
                    if (match_d) begin
                        next_wave = com_d == tpc_pkg::COM_SET;
                    end else if (zero_d) begin
                        next_wave = com_d != tpc_pkg::COM_SET;
                    end
                end
                tpc_pkg::WM_PFC, tpc_pkg::WM_DS6: begin
                    if (match_d) begin
                        next_wave = (com_d == tpc_pkg::COM_SET) ^ count_down_in;
                    end
                end
                default: next_wave = wave;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            wave   <= 1'b0;
            wave_n <= 1'b1;
        end else begin
            wave   <= next_wave;
            wave_n <= !next_wave;
        end
    end

    // Pin connection; fault hold drops both drivers
    assign inv_conn                  = (wmode != tpc_pkg::WM_NORMAL) && (com_d == tpc_pkg::COM_TOG);
    assign chan_d_waveform_out       = wave;
    assign chan_d_compare_pin_out    = wave;
    assign chan_d_inv_pin_out        = wave_n;
    assign chan_d_override_out       = com_d != tpc_pkg::COM_OFF;
    assign chan_d_inv_override_out   = inv_conn;
    assign chan_d_compare_pin_oe_out = chan_d_override_out && chan_d_dir_in && !hold;
    assign chan_d_inv_pin_oe_out     = inv_conn && chan_d_inv_dir_in && !hold;

    tpc_prescaler u_presc (
        .clk_in   (clk_sys_in),
        .rst_n_in (rst_n),
        .bus      (u_core_if.presc)
    );

    tpc_fault_front u_fault (
        .clk_in             (clk_sys_in),
        .rst_n_in           (rst_n),
        .fault_input_pin_in (fault_input_pin_in),
        .comparator_in      (comparator_in),
        .bus                (u_core_if.fault)
    );

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n);

    property p_force_read;
        (setup && !pwrite_in && hit_cdc) |=> !prdata_out[tpc_pkg::CDC_FORCE];
    endproperty
    a_force_read: assert property (p_force_read) else $error("force bit read as one");

    property p_toggle;
        (wmode == tpc_pkg::WM_NORMAL && com_d == tpc_pkg::COM_TOG && match_d && !force_now)
        |=> (wave != $past(wave)) && (wave_n == !wave);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle on normal mode match");

    property p_fast_zero;
        (wmode == tpc_pkg::WM_FAST && com_d == tpc_pkg::COM_CLR && zero_d && !match_d && !force_now)
        |=> wave;
    endproperty
    a_fast_zero: assert property (p_fast_zero) else $error("fast mode not set at zero");

    property p_pfc_down;
        (wmode == tpc_pkg::WM_PFC && com_d == tpc_pkg::COM_SET && match_d && count_down_in && !force_now)
        |=> !wave;
    endproperty
    a_pfc_down: assert property (p_pfc_down) else $error("inverted pfc not cleared on down match");

    property p_force_ignored;
        (wr && hit_cdc && pwdata_in[tpc_pkg::CDC_FORCE] && pwdata_in[tpc_pkg::CDC_PWM] && !match_d && !zero_d)
        |=> $stable(wave);
    endproperty
    a_force_ignored: assert property (p_force_ignored) else $error("force acted in PWM");

    property p_force_set;
        (wr && hit_cdc && pwdata_in[tpc_pkg::CDC_FORCE] && !pwdata_in[tpc_pkg::CDC_PWM]
         && pwdata_in[tpc_pkg::CDC_D_LSB +: 2] == tpc_pkg::COM_SET && !match_d)
        |=> wave && !chan_d_match_out;
    endproperty
    a_force_set: assert property (p_force_set) else $error("force did not set with new mode");

    property p_flag_clear;
        (wr && hit_fwc && pwdata_in[tpc_pkg::FWC_FLAG] && fault_flag && !u_core_if.fault_event)
        ##1 !u_core_if.fault_event |-> fault_flag ##1 !fault_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag clear timing wrong");

    property p_irq;
        (u_core_if.fault_event && fwc[tpc_pkg::FWC_IRQ_EN] && !wr) |=> fault_irq_out && fault_flag;
    endproperty
    a_irq: assert property (p_irq) else $error("fault event raised no request");

    property p_irq_gate;
        !fwc[tpc_pkg::FWC_IRQ_EN] |-> !fault_irq_out;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request without enable");

    property p_inv_oe;
        chan_d_inv_pin_oe_out |-> cdc[tpc_pkg::CDC_PWM] && com_d == tpc_pkg::COM_TOG && chan_d_inv_dir_in;
    endproperty
    a_inv_oe: assert property (p_inv_oe) else $error("inverted pin driven outside PWM 01");

    property p_override;
        (com_d != tpc_pkg::COM_OFF && chan_d_dir_in && !fault_protect_out) |-> chan_d_compare_pin_oe_out;
    endproperty
    a_override: assert property (p_override) else $error("compare pin not driven");

    c_force: cover property (force_now ##1 wave);
    c_fault: cover property (u_core_if.fault_event ##1 fault_irq_out);
    c_fast:  cover property ((wmode == tpc_pkg::WM_FAST) && match_d ##[1:50] zero_d);
endmodule

/* tb/tpc_pins_model.sv */
// Far-side model: fault sources and compare pin pad
`timescale 1ns/1ps
module tpc_pins_model (
    input  wire logic clk_in,
    input  wire logic fault_lvl_in,
    input  wire logic pin_in,
    input  wire logic pin_oe_in,
    output logic      fault_pin_out,
    output logic      comp_out,
    output logic      pad_out
);
    // Pad pulled up while the driver is off
    assign pad_out = pin_oe_in ? pin_in : 1'b1;
    always_ff @(posedge clk_in) begin
        fault_pin_out <= fault_lvl_in;
        comp_out      <= !fault_lvl_in;
    end
endmodule

/* tb/timer_prescale_compare_d_fault_ctrl_bench.sv */
// Self-checking bench for the timer control block
`timescale 1ns/1ps
module timer_prescale_compare_d_fault_ctrl_bench;
    logic clk_sys_in = 0, nrst_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, flvl = 0;
    logic [11:0] paddr_in = 0;
    logic [31:0] pwdata_in = 0, prdata_out, rd, d;
    logic fast_periph_clk_in = 0, count_down_in = 0, chan_d_dir_in = 1, chan_d_inv_dir_in = 1;
    logic [9:0] timer_count_in = 0;
    logic fault_input_pin_in, comparator_in, fault_irq_ack_in = 0, pad, err, w;
    logic pready_out, pslverr_out, timer_tick_out, timer_enable_out, chan_d_match_out;
    logic chan_d_waveform_out, chan_d_compare_pin_out, chan_d_compare_pin_oe_out, chan_d_override_out;
    logic chan_d_inv_pin_out, chan_d_inv_pin_oe_out, chan_d_inv_override_out, fault_irq_out, fault_protect_out;
    logic [2:0] wave_mode_out;
    logic [1:0] chan_a_mode_shadow_out, chan_b_mode_shadow_out;
    logic [1:0] fm [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
    int n_fail = 0, comparisons = 0, k, j, seed = 32'h2c7c_012b;
    tpc_top u_tpc_top (.clk_sys_in, .nrst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .fast_periph_clk_in, .timer_count_in, .count_down_in,
        .timer_tick_out, .timer_enable_out, .wave_mode_out, .chan_a_mode_shadow_out, .chan_b_mode_shadow_out,
        .chan_d_match_out, .chan_d_waveform_out, .chan_d_dir_in, .chan_d_inv_dir_in, .chan_d_compare_pin_out,
        .chan_d_compare_pin_oe_out, .chan_d_override_out, .chan_d_inv_pin_out, .chan_d_inv_pin_oe_out,
        .chan_d_inv_override_out, .fault_input_pin_in, .comparator_in, .fault_irq_ack_in, .fault_irq_out,
        .fault_protect_out);
    tpc_pins_model u_tpc_pins_model (.clk_in(clk_sys_in), .fault_lvl_in(flvl), .pin_in(chan_d_compare_pin_out),
        .pin_oe_in(chan_d_compare_pin_oe_out), .fault_pin_out(fault_input_pin_in), .comp_out(comparator_in),
        .pad_out(pad));
    initial forever #4 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) fast_periph_clk_in <= 1'($random(seed));
    function automatic logic f_act(input logic [1:0] m, input logic v);
        return m == 2'h1 ? !v : (m[1] ? m[0] : v);
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] dat);
        @(posedge clk_sys_in);
        psel_in <= 1;
        pwrite_in <= wr;
        paddr_in <= {2'h0, idx, 2'h0};
        pwdata_in <= dat;
        @(posedge clk_sys_in);
        penable_in <= 1;
        do begin
            @(posedge clk_sys_in);
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 0;
        penable_in <= 0;
    endtask
    task automatic ev(input logic [9:0] c, input logic dn, input logic e);
        @(posedge clk_sys_in) timer_count_in <= 10'h055;
        @(posedge clk_sys_in) timer_count_in <= c;
        count_down_in <= dn;
        @(posedge clk_sys_in);
        #1 chk(chan_d_match_out, c == 10'h100, "match pulse");
        @(posedge clk_sys_in);
        #1 chk({chan_d_waveform_out, chan_d_inv_pin_out}, {e, !e}, "pwm wave");
    endtask
    task automatic waitf(input logic [7:0] fwc);
        if (fwc != 0) apb(1, tpc_pkg::IDX_FWC, fwc);
        repeat (12) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic results;
        $display("mismatches %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #100_000;
        n_fail++;
        results();
    end
    initial begin
        repeat (4) @(posedge clk_sys_in);
        nrst_in <= 1;
        repeat (3) @(posedge clk_sys_in);
        apb(0, tpc_pkg::IDX_FWC, 0);
        chk(rd, 0, "fwc reset");
        apb(0, 8'h3f, 0);
        chk(err, 1, "unmapped");
        repeat (4) begin
            d = $random(seed);
            apb(1, tpc_pkg::IDX_CDC, d & 8'hF2);
            #1 chk({chan_a_mode_shadow_out, chan_b_mode_shadow_out}, d[7:4], "shadow");
            apb(0, tpc_pkg::IDX_CDC, 0);
            chk(rd, d & 8'hF0, "readback");
        end
        w = 0;
        foreach (fm[i]) begin
            apb(1, tpc_pkg::IDX_CDC, {fm[i], 2'h2});
            w = f_act(fm[i], w);
            repeat (2) @(posedge clk_sys_in);
            #1 chk(chan_d_waveform_out, w, "force");
            chk({pad, chan_d_match_out, chan_d_inv_override_out}, {w, 2'b00}, "pin");
        end
        @(posedge clk_sys_in) chan_d_dir_in <= 0;
        #1 chk({pad, chan_d_compare_pin_oe_out}, 2'b10, "pad released");
        @(posedge clk_sys_in) chan_d_dir_in <= 1;
        apb(1, tpc_pkg::IDX_CMPD, 10'h100);
        for (int g = 0; g < 2; g++) begin
            for (int m = 1; m < 4; m++) begin
                apb(1, tpc_pkg::IDX_FWC, g);
                apb(1, tpc_pkg::IDX_CDC, {m[1:0], 2'h3});
                #1 chk({wave_mode_out, chan_d_inv_override_out}, {3'(g + 1), m == 1}, "pwm mode");
                chk({chan_d_override_out, chan_d_inv_pin_oe_out}, {1'b1, m == 1}, "pin drive");
                ev(10'h100, 0, m == 3);
                ev(10'h000, 0, (m == 3) ^ !g);
                ev(10'h100, 1, (m == 3) ^ g);
                apb(1, tpc_pkg::IDX_CDC, {m[1:0], 2'h3});
                #1 chk(chan_d_waveform_out, (m == 3) ^ g, "force in pwm");
            end
        end
        apb(1, tpc_pkg::IDX_CDC, 32'h0000_0004);
        #1 chk({wave_mode_out, chan_d_inv_override_out}, 0, "normal");
        ev(10'h100, 0, 1);
        for (int n = 1; n < 6; n++) begin
            apb(1, tpc_pkg::IDX_CLK, n == 5 ? 32'h0000_0011 : n);
            #1 chk(timer_enable_out, 1, "enable");
            repeat (16) @(posedge clk_sys_in);
            k = 0;
            j = 0;
            repeat (64) begin
                @(negedge clk_sys_in);
                if (timer_tick_out === 1'b1) k++;
                if (fast_periph_clk_in === 1'b1) j++;
            end
            chk(k, n == 5 ? j : 64 >> (n - 1), "ticks");
        end
        apb(1, tpc_pkg::IDX_CLK, 0);
        #1 chk(timer_enable_out, 0, "stop");
        apb(1, tpc_pkg::IDX_FWC, 8'hD0);
        @(posedge clk_sys_in) flvl <= 1;
        waitf(0);
        chk({fault_irq_out, fault_protect_out}, 2'b11, "fault");
        @(posedge clk_sys_in) fault_irq_ack_in <= 1;
        @(posedge clk_sys_in) fault_irq_ack_in <= 0;
        @(posedge clk_sys_in) flvl <= 0;
        waitf(0);
        chk(fault_irq_out, 0, "ack, fall ignored");
        apb(1, tpc_pkg::IDX_FWC, 8'h18);
        apb(1, tpc_pkg::IDX_FWC, 8'h58);
        @(posedge clk_sys_in) flvl <= 1;
        waitf(0);
        chk(fault_protect_out, 0, "pin unrouted");
        @(posedge clk_sys_in) flvl <= 0;
        waitf(0);
        chk({fault_protect_out, fault_irq_out}, 2'b10, "comparator");
        apb(1, tpc_pkg::IDX_FWC, 8'h5C);
        repeat (2) @(posedge clk_sys_in);
        #1 chk(fault_protect_out, 0, "w1c");
        apb(1, tpc_pkg::IDX_FWC, 8'h78);
        @(posedge clk_sys_in) flvl <= 1;
        repeat (2) @(posedge clk_sys_in);
        flvl <= 0;
        waitf(0);
        chk(fault_protect_out, 0, "glitch filtered");
        @(posedge clk_sys_in) flvl <= 1;
        waitf(0);
        @(posedge clk_sys_in) flvl <= 0;
        waitf(0);
        chk(fault_protect_out, 1, "filtered edge");
        results();
    end
endmodule
